// *** frt_pkg.sv ***
// Package for the free-running input capture timer
package frt_pkg;
	// Register byte offsets
	localparam logic [7:0] FRT_COUNT_OFF = 8'h00;
	localparam logic [7:0] FRT_CTRL_OFF = 8'h04;
	localparam logic [7:0] FRT_CAP_CTRL_OFF = 8'h08;
	localparam logic [7:0] FRT_CAP_STAT_OFF = 8'h0c;
	localparam logic [7:0] FRT_CAP0_OFF = 8'h10;
	// Control register fields
	localparam int FRT_CTRL_DIV_LSB = 0;
	localparam int FRT_CTRL_RUN_BIT = 2;
	localparam int FRT_CTRL_CLR_BIT = 3;
	localparam int FRT_CTRL_OVIE_BIT = 4;
	localparam int FRT_CTRL_OVF_BIT = 5;
	// Capture status fields
	localparam int FRT_STAT_IE_LSB = 4;
	// Reset values
	localparam logic [15:0] FRT_COUNT_RST = 16'h0000;
	localparam logic [1:0] FRT_DIV_RST = 2'h0;
	// Interrupt vector of the counter overflow request
	localparam logic [7:0] FRT_OVF_VECTOR = 8'h13;
	// Edge select codes
	localparam logic [1:0] FRT_EDGE_OFF = 2'h0;
	localparam logic [1:0] FRT_EDGE_RISE = 2'h1;
	localparam logic [1:0] FRT_EDGE_FALL = 2'h2;
	localparam logic [1:0] FRT_EDGE_BOTH = 2'h3;
	// Prescaler dividing ratios as log2: 2, 4, 8, 16
	localparam logic [3:0] FRT_DIV_LOG0 = 4'h1;
	localparam logic [3:0] FRT_DIV_STEP = 4'h1;
	localparam int FRT_CH_NUM = 4;
endpackage

// *** frt_edge_cap.sv ***
// One capture channel: input synchroniser, edge detect, data latch
`timescale 1ns/1ps
module frt_edge_cap
	import frt_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// Pin and configuration
	input wire logic i_pin,
	input wire logic [1:0] i_edge_sel,
	input wire logic [W-1:0] i_time_base,
	// Results
	output logic [W-1:0] o_cap_data,
	output logic o_cap_evt
);
	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;
	logic hit;

	// RULE11: two-stage synchroniser
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			sync1_reg <= i_pin;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// RULE8: edge polarity select
	always_comb begin
		unique case (i_edge_sel)
			FRT_EDGE_RISE: hit = sync2_reg & ~prev_reg;
			FRT_EDGE_FALL: hit = ~sync2_reg & prev_reg;
			FRT_EDGE_BOTH: hit = sync2_reg ^ prev_reg;
			default: hit = 1'b0;
		endcase
	end

	// RULE7: latch time base
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_cap_data <= '0;
			o_cap_evt <= 1'b0;
		end else begin
			o_cap_evt <= hit;
			if (hit) begin
				o_cap_data <= i_time_base;
			end
		end
	end
endmodule // frt_edge_cap

// *** frt_timer.sv ***
// Free-running 16-bit timer with four input capture channels
//
// How it works
// RULE1: counter advances once per prescaled tick; ratio set by control field.
// RULE2: wrap sets overflow flag; enabled flag raises interrupt and transfer request.
// RULE3: reset or count_zero_bit write forces the counter to zero.
// RULE4: live counter value feeds every capture channel as time base.
// RULE5: overflow request is tagged with interrupt vector number 19.
// RULE6: count register reads live value; writes load it only while halted.
// RULE7: selected edge latches the counter into that pin's capture register.
// RULE8: each channel selects rising, falling or both edges.
// RULE9: capture edge sets a flag raising interrupt and transfer request.
// RULE10: two units of two pins give four capture channels.
// RULE11: pins synchronised first; one edge gives exactly one capture event.
// RULE12: overflow is all-ones to zero wrap; counting continues.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module frt_timer
	import frt_pkg::*;
#(
	parameter int W = 16,
	parameter int NCH = FRT_CH_NUM
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Capture pins
	input wire logic [NCH-1:0] i_cap_pin,
	// Requests
	output logic o_ovf_irq,
	output logic [7:0] o_ovf_vector,
	output logic o_cap_irq,
	output logic o_xfer_req
);
	logic [W-1:0] count_reg;
	logic [1:0] div_reg;
	logic run_reg;
	logic ovie_reg;
	logic ovf_reg;
	logic [2*NCH-1:0] edge_sel_reg;
	logic [NCH-1:0] cap_ie_reg;
	logic [NCH-1:0] cap_flag_reg;
	logic [15:0] pre_reg;
	logic tick;
	logic wr_en;
	logic rd_en;
	logic [NCH-1:0] cap_evt;
	logic [W-1:0] cap_data [NCH];
	logic [3:0] div_log;

	assign wr_en = i_psel & i_penable & i_pwrite;
	assign rd_en = i_psel & i_penable & ~i_pwrite;

	function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] off);
		hit_addr = (a == off);
	endfunction

	// RULE1: prescaler ratio decode
	assign div_log = FRT_DIV_LOG0 + 4'(div_reg) * FRT_DIV_STEP;
	assign tick = run_reg && (pre_reg[div_log - 4'h1 +: 1] == 1'b1)
		&& ((pre_reg & ((16'h0001 << div_log) - 16'h0001))
		== ((16'h0001 << div_log) - 16'h0001));

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			pre_reg <= 16'h0000;
		end else if (!run_reg) begin
			pre_reg <= 16'h0000;
		end else begin
			pre_reg <= pre_reg + 16'h0001;
		end
	end

	// Counter: clear beats load beats count
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			// RULE3: reset clear
			count_reg <= FRT_COUNT_RST;
		end else if (wr_en && hit_addr(i_paddr, FRT_CTRL_OFF) && i_pwdata[FRT_CTRL_CLR_BIT]) begin
			// RULE3: software clear
			count_reg <= FRT_COUNT_RST;
		end else if (wr_en && hit_addr(i_paddr, FRT_COUNT_OFF) && !run_reg) begin
			// RULE6: load while halted
			count_reg <= i_pwdata[W-1:0];
		end else if (tick) begin
			// RULE12: plain wrap, keeps counting
			count_reg <= count_reg + W'(1);
		end
	end

	// Control bits
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			div_reg <= FRT_DIV_RST;
			run_reg <= 1'b0;
			ovie_reg <= 1'b0;
			edge_sel_reg <= '0;
			cap_ie_reg <= '0;
		end else if (wr_en) begin
			if (hit_addr(i_paddr, FRT_CTRL_OFF)) begin
				div_reg <= i_pwdata[FRT_CTRL_DIV_LSB +: 2];
				run_reg <= i_pwdata[FRT_CTRL_RUN_BIT];
				ovie_reg <= i_pwdata[FRT_CTRL_OVIE_BIT];
			end
			if (hit_addr(i_paddr, FRT_CAP_CTRL_OFF)) begin
				// RULE8: edge selects per channel
				edge_sel_reg <= i_pwdata[2*NCH-1:0];
			end
			if (hit_addr(i_paddr, FRT_CAP_STAT_OFF)) begin
				cap_ie_reg <= i_pwdata[FRT_STAT_IE_LSB +: NCH];
			end
		end
	end

	// RULE12: overflow flag, set wins over a write-zero clear
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			ovf_reg <= 1'b0;
		end else if (tick && count_reg == {W{1'b1}}) begin
			ovf_reg <= 1'b1;
		end else if (wr_en && hit_addr(i_paddr, FRT_CTRL_OFF) && !i_pwdata[FRT_CTRL_OVF_BIT]) begin
			ovf_reg <= 1'b0;
		end
	end

	// RULE10: four channels in two units of two
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			// RULE4: shared time base
			frt_edge_cap #(
				.W(W)
			) u_cap (
				.i_mclk(i_mclk),
				.i_reset(i_reset),
				.i_pin(i_cap_pin[g]),
				.i_edge_sel(edge_sel_reg[2*g +: 2]),
				.i_time_base(count_reg),
				.o_cap_data(cap_data[g]),
				.o_cap_evt(cap_evt[g])
			);

			// RULE9: capture flag, set wins over write-zero clear
			always_ff @(posedge i_mclk) begin
				if (i_reset) begin
					cap_flag_reg[g] <= 1'b0;
				end else if (cap_evt[g]) begin
					cap_flag_reg[g] <= 1'b1;
				end else if (wr_en && hit_addr(i_paddr, FRT_CAP_STAT_OFF) && !i_pwdata[g]) begin
					cap_flag_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Request outputs registered
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_ovf_irq <= 1'b0;
			o_cap_irq <= 1'b0;
			o_xfer_req <= 1'b0;
			o_ovf_vector <= FRT_OVF_VECTOR;
		end else begin
			// RULE2: overflow request
			o_ovf_irq <= ovf_reg & ovie_reg;
			// RULE9: capture request
			o_cap_irq <= |(cap_flag_reg & cap_ie_reg);
			o_xfer_req <= (ovf_reg & ovie_reg) | (|(cap_flag_reg & cap_ie_reg));
			// RULE5: vector number 19
			o_ovf_vector <= FRT_OVF_VECTOR;
		end
	end

	// APB read path; zero-wait answer, unmapped reads zero with error
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_prdata <= 32'h0000_0000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel & ~i_penable;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
			if (i_psel && !i_penable) begin
				unique case (i_paddr)
					// RULE6: live count readback
					FRT_COUNT_OFF: o_prdata <= {16'h0000, count_reg};
					FRT_CTRL_OFF: o_prdata <= {26'h0, ovf_reg, ovie_reg, 1'b0, run_reg, div_reg};
					FRT_CAP_CTRL_OFF: o_prdata <= {24'h0, edge_sel_reg};
					FRT_CAP_STAT_OFF: o_prdata <= {24'h0, cap_ie_reg, cap_flag_reg};
					FRT_CAP0_OFF: o_prdata <= {16'h0000, cap_data[0]};
					FRT_CAP0_OFF + 8'h04: o_prdata <= {16'h0000, cap_data[1]};
					FRT_CAP0_OFF + 8'h08: o_prdata <= {16'h0000, cap_data[2]};
					FRT_CAP0_OFF + 8'h0c: o_prdata <= {16'h0000, cap_data[3]};
					default: o_pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule // frt_timer

// *** frt_timer_assertions.sv ***
// Bus and request checks for the capture timer
`timescale 1ns/1ps
module frt_timer_chk
	import frt_pkg::*;
#(parameter int NCH = FRT_CH_NUM) (
	input wire logic i_mclk, i_reset, i_psel, i_penable, i_pwrite,
	input wire logic [7:0] i_paddr, o_ovf_vector,
	input wire logic [31:0] i_pwdata, o_prdata,
	input wire logic o_pready, o_pslverr, o_ovf_irq, o_cap_irq, o_xfer_req,
	input wire logic [NCH-1:0] i_cap_pin
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	wire w = i_psel & i_penable & i_pwrite;
	property p_vec; o_ovf_vector == FRT_OVF_VECTOR; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
	a_rdy: assert property (p_rdy) else $error("late ready");
	property p_one; o_pready |-> $past(i_psel && !i_penable); endproperty
	a_one: assert property (p_one) else $error("stray ready");
	property p_err;
		o_pslverr |-> o_pready && (($past(i_paddr) > 8'h1c) || ($past(i_paddr[1:0]) != 2'h0));
	endproperty
	a_err: assert property (p_err) else $error("bad slave error");
	property p_hi; o_pready |-> o_prdata[31:16] == 16'h0000; endproperty
	a_hi: assert property (p_hi) else $error("upper bits set");
	property p_xf; o_ovf_irq || o_cap_irq |-> ##[0:1] o_xfer_req; endproperty
	a_xf: assert property (p_xf) else $error("no transfer request");
	property p_ofl; $fell(o_ovf_irq) |-> $past(w) || $past(w, 2); endproperty
	a_ofl: assert property (p_ofl) else $error("overflow request lost");
	property p_cfl; $fell(o_cap_irq) |-> $past(w) || $past(w, 2); endproperty
	a_cfl: assert property (p_cfl) else $error("capture request lost");
endmodule // frt_timer_chk
bind frt_timer frt_timer_chk #(.NCH(NCH)) u_chk (.i_mclk, .i_reset, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .o_ovf_vector, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
	.o_ovf_irq, .o_cap_irq, .o_xfer_req, .i_cap_pin);

// *** frt_pin_src.sv ***
// Source model driving the capture pins
`timescale 1ns/1ps
module frt_pin_src (
	input wire logic i_mclk,
	input wire logic [3:0] i_level,
	output logic [3:0] o_pin = 4'h0
);
	// Pins move just after the edge, as a clocked source would
	always @(posedge i_mclk) o_pin <= i_level;
endmodule // frt_pin_src

// *** frt_timer_test.sv ***
// Register-level tests of the capture timer
`timescale 1ns/1ps
module frt_timer_test
	import frt_pkg::*;
;
	logic i_mclk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic o_pready, o_pslverr, o_ovf_irq, o_cap_irq, o_xfer_req, err;
	logic [7:0] i_paddr = 0, o_ovf_vector;
	logic [31:0] i_pwdata = 0, o_prdata, q;
	logic [31:0] ecap [4] = '{16'habc, 16'hdef, 16'hdef, 0};
	logic [3:0] lvl = 0, pins;
	int fails = 0, num_checks = 0, cyc = 0;
	always #4 i_mclk = ~i_mclk;
	frt_pin_src i_src (.i_mclk, .i_level(lvl), .o_pin(pins));
	frt_timer i_dut (.i_mclk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
		.o_prdata, .o_pready, .o_pslverr, .i_cap_pin(pins), .o_ovf_irq, .o_ovf_vector,
		.o_cap_irq, .o_xfer_req);
	task automatic chk(input logic [31:0] g, e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Ready and data are taken at the rising edge, before that edge's updates land
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1;
		do @(posedge i_mclk); while (o_pready !== 1);
		q = o_prdata;
		err = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(q, e);
	endtask
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		if (++cyc == 5000) begin
			fails++;
			end_of_test;
		end
	end
	initial begin
		repeat (4) @(posedge i_mclk);
		i_reset <= 0;
		rchk(FRT_COUNT_OFF, 0);
		rchk(FRT_CTRL_OFF, 0);
		apb(0, 8'h40, 0);
		chk(err, 1);
		$display("reset test done");
		// Prescaler restarts from zero, so the count lands one tick short; one tick either way is allowed
		for (int d = 0; d < 4; d++) begin
			apb(1, FRT_COUNT_OFF, 0);
			apb(1, FRT_CTRL_OFF, 4 + d);
			repeat (60) @(posedge i_mclk);
			apb(1, FRT_CTRL_OFF, d);
			apb(0, FRT_COUNT_OFF, 0);
			chk(q + 1 - (64 >> (d + 1)) <= 2, 1);
		end
		$display("prescaler test done");
		apb(1, FRT_COUNT_OFF, 16'hfffe);
		rchk(FRT_COUNT_OFF, 16'hfffe);
		apb(1, FRT_CTRL_OFF, 8'h14);
		repeat (8) @(negedge i_mclk);
		chk({o_ovf_irq, o_xfer_req, o_ovf_vector}, 12'h313);
		apb(1, FRT_COUNT_OFF, 16'h1234);
		apb(0, FRT_COUNT_OFF, 0);
		chk(q < 32, 1);
		apb(1, FRT_CTRL_OFF, 8'h1c);
		apb(0, FRT_COUNT_OFF, 0);
		chk({o_ovf_irq, q < 4}, 1);
		$display("overflow test done");
		apb(1, FRT_CTRL_OFF, 0);
		apb(1, FRT_COUNT_OFF, 16'h0abc);
		apb(1, FRT_CAP_CTRL_OFF, 8'h39);
		apb(1, FRT_CAP_STAT_OFF, 8'hf0);
		lvl <= 4'hf;
		repeat (8) @(negedge i_mclk);
		rchk(FRT_CAP_STAT_OFF, 8'hf5);
		chk(o_cap_irq, 1);
		apb(1, FRT_COUNT_OFF, 16'h0def);
		lvl <= 4'h0;
		repeat (8) @(negedge i_mclk);
		rchk(FRT_CAP_STAT_OFF, 8'hf7);
		for (int c = 0; c < 4; c++) rchk(FRT_CAP0_OFF + 8'(4 * c), ecap[c]);
		apb(1, FRT_CAP_STAT_OFF, 8'hf0);
		// Request output is registered one edge after the flag clears
		repeat (2) @(negedge i_mclk);
		chk(o_cap_irq, 0);
		$display("capture test done");
		end_of_test;
	end
endmodule // frt_timer_test
